// File: logic/lait_bus_slave.sv
`timescale 1ns/10ps
`default_nettype none
`include "lait_consts.svh"

module lait_bus_slave (
    input wire logic clk, // System clock
    input wire logic rst_n, // Synchronised reset, active low
    input wire logic ce, // Clock enable
    input wire logic scl_i, // Serial clock pin
    input wire logic sda_i, // Serial data pin level
    output logic sda_oe, // Pull data line low
    output logic wr_stb, // Register write pulse
    output logic [7:0] wr_addr, // Write offset
    output logic [7:0] wr_data, // Write value
    output logic [7:0] rd_addr, // Read offset
    input wire logic [7:0] rd_data // Read value at rd_addr
);
    import lait_pkg::*;

    logic scl_s1_r, scl_s2_r, scl_d_r, sda_s1_r, sda_s2_r, sda_d_r;
    logic scl_rise, scl_fall, start_c, stop_c;
    lait_bus_st_e state_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] sh_r, tx_r, ptr_r;
    logic rw_r, first_r, nack_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else if (ce) begin
            scl_s1_r <= scl_i;
            scl_s2_r <= scl_s1_r;
            scl_d_r <= scl_s2_r;
            sda_s1_r <= sda_i;
            sda_s2_r <= sda_s1_r;
            sda_d_r <= sda_s2_r;
        end
    end

    assign scl_rise = scl_s2_r && !scl_d_r;
    assign scl_fall = !scl_s2_r && scl_d_r;
    assign start_c = scl_s2_r && scl_d_r && sda_d_r && !sda_s2_r;
    assign stop_c = scl_s2_r && scl_d_r && !sda_d_r && sda_s2_r;
    assign rd_addr = ptr_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= lait_st_idle;
            bit_cnt_r <= 4'h0;
            sh_r <= 8'h00;
            tx_r <= 8'h00;
            ptr_r <= 8'h00;
            rw_r <= 1'b0;
            first_r <= 1'b0;
            nack_r <= 1'b0;
            sda_oe <= 1'b0;
            wr_stb <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
        end else if (ce) begin
            wr_stb <= 1'b0;
            if (start_c) begin
                state_r <= lait_st_addr;
                bit_cnt_r <= 4'h0;
                first_r <= 1'b1;
                sda_oe <= 1'b0;
            end else if (stop_c) begin
                state_r <= lait_st_idle;
                sda_oe <= 1'b0;
            end else if (scl_rise) begin
                case (state_r)
                    lait_st_addr, lait_st_wrb: begin
                        sh_r <= {sh_r[6:0], sda_s2_r};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end
                    lait_st_ack_r: nack_r <= sda_s2_r;
                    default: ;
                endcase
            end else if (scl_fall) begin
                case (state_r)
                    lait_st_addr: begin
                        if (bit_cnt_r == 4'h8) begin
                            if (sh_r[7:1] == `LAIT_BUS_ADDR) begin
                                sda_oe <= 1'b1;
                                rw_r <= sh_r[0];
                                state_r <= lait_st_ack_a;
                            end else begin
                                state_r <= lait_st_idle;
                            end
                        end
                    end
                    lait_st_ack_a, lait_st_ack_r: begin
                        if (state_r == lait_st_ack_r && nack_r) begin
                            sda_oe <= 1'b0;
                            state_r <= lait_st_idle;
                        end else if (state_r == lait_st_ack_r || rw_r) begin
                            tx_r <= rd_data;
                            sda_oe <= !rd_data[7];
                            bit_cnt_r <= 4'h1;
                            state_r <= lait_st_rdb;
                        end else begin
                            sda_oe <= 1'b0;
                            bit_cnt_r <= 4'h0;
                            state_r <= lait_st_wrb;
                        end
                    end
                    lait_st_wrb: begin
                        if (bit_cnt_r == 4'h8) begin
                            sda_oe <= 1'b1;
                            state_r <= lait_st_ack_w;
                            if (first_r) begin
                                ptr_r <= sh_r;
                                first_r <= 1'b0;
                            end else begin
                                wr_stb <= 1'b1;
                                wr_addr <= ptr_r;
                                wr_data <= sh_r;
                                ptr_r <= ptr_r + 8'h01;
                            end
                        end
                    end
                    lait_st_ack_w: begin
                        sda_oe <= 1'b0;
                        bit_cnt_r <= 4'h0;
                        state_r <= lait_st_wrb;
                    end
                    lait_st_rdb: begin
                        if (bit_cnt_r == 4'h8) begin
                            sda_oe <= 1'b0;
                            ptr_r <= ptr_r + 8'h01;
                            state_r <= lait_st_ack_r;
                        end else begin
                            tx_r <= {tx_r[6:0], 1'b0};
                            sda_oe <= !tx_r[6];
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end
                    end
                    default: state_r <= lait_st_idle;
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// File: logic/lait_consts.svh
`ifndef LAIT_CONSTS_SVH
`define LAIT_CONSTS_SVH

// Clock and conversion oscillator rates
`define LAIT_REF_CLK_KHZ 250000
`define LAIT_FOSC_FULL_KHZ 655
`define LAIT_FOSC_HALF_KHZ 327
`define LAIT_DIV_FULL (`LAIT_REF_CLK_KHZ / `LAIT_FOSC_FULL_KHZ)
`define LAIT_DIV_HALF (`LAIT_REF_CLK_KHZ / `LAIT_FOSC_HALF_KHZ)

// Register offsets
`define LAIT_ADDR_CMD 8'h00
`define LAIT_ADDR_CTRL 8'h01
`define LAIT_ADDR_DATA_LO 8'h04
`define LAIT_ADDR_DATA_HI 8'h05
`define LAIT_ADDR_TMR_LO 8'h06
`define LAIT_ADDR_TMR_HI 8'h07

// Field positions
`define LAIT_CMD_ENABLE 7
`define LAIT_CMD_SYNC 6
`define LAIT_CMD_EXT_TIMING 5
`define LAIT_CMD_MODE_HI 3
`define LAIT_CMD_MODE_LO 2
`define LAIT_CMD_RES_HI 1
`define LAIT_CMD_RES_LO 0
`define LAIT_CTRL_GAIN_HI 3
`define LAIT_CTRL_GAIN_LO 2

// Reset values
`define LAIT_CMD_RESET 8'h00
`define LAIT_CTRL_RESET 8'h00

// Last oscillator cycle of an internal integration, per resolution
`define LAIT_PERIOD_M1_16 16'hFFFF
`define LAIT_PERIOD_M1_12 16'h0FFF
`define LAIT_PERIOD_M1_8 16'h00FF
`define LAIT_PERIOD_M1_4 16'h000F

// Serial bus device address, value arbitrary
`define LAIT_BUS_ADDR 7'h2A

`endif

// File: logic/lait_pkg.sv
package lait_pkg;

    typedef enum logic [1:0] {
        lowest_gain_setting = 2'b00,
        second_gain_setting = 2'b01,
        third_gain_setting = 2'b10,
        highest_gain_setting = 2'b11
    } lait_gain_e;

    typedef enum logic [1:0] {
        lait_res_16 = 2'b00,
        lait_res_12 = 2'b01,
        lait_res_8 = 2'b10,
        lait_res_4 = 2'b11
    } lait_res_e;

    typedef enum logic [1:0] {
        single_diode_mode_a = 2'b00,
        single_diode_mode_b = 2'b01,
        lait_mode_spare = 2'b10,
        dual_diode_sequence_mode = 2'b11
    } lait_dmode_e;

    typedef enum logic [2:0] {
        lait_st_idle = 3'b000,
        lait_st_addr = 3'b001,
        lait_st_ack_a = 3'b010,
        lait_st_wrb = 3'b011,
        lait_st_ack_w = 3'b100,
        lait_st_rdb = 3'b101,
        lait_st_ack_r = 3'b110
    } lait_bus_st_e;

endpackage

// File: logic/lait_top.sv
// Function
// - The conversion oscillator runs at half rate for the two lower gain settings and full rate for the two higher.
// - Bit 5 of the command register at 00h selects external rather than internal integration timing.
// - In internal timing each integration lasts exactly 2^n oscillator cycles, n being 16, 12, 8 or 4 for command bits 1:0 of 0 to 3.
// - In external timing a 1 written to the sync bit ends the running integration and starts a new one.
// - In single-diode external modes the first sync only starts an integration, a later one completes it.
// - In dual-diode sequence mode syncs alternate diode one and diode two, each sync ending the current one.
// - In external timing the oscillator keeps its rate and a 16-bit counter tallies its cycles.
// - At each integration end in external timing the cycle count is captured into timer bytes 06h (low) and 07h (high).
// - The result bytes from 04h are refreshed after every completed integration.
`timescale 1ns/10ps
`default_nettype none
`include "lait_consts.svh"

module lait_top (
    input wire logic ref_clk, // 250 MHz system clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic ce, // Clock enable, freezes all state
    input wire logic scl_i, // Serial clock pin
    input wire logic sda_i, // Serial data pin level
    output logic sda_o, // Serial data drive value
    output logic sda_oe, // Serial data drive enable
    input wire logic adc_pulse, // Modulator count pulse, ref_clk domain
    output logic diode_sel, // 0 diode one, 1 diode two
    output logic integrating, // Integration running
    output logic result_stb // Results refreshed pulse
);
    import lait_pkg::*;

    localparam logic [9:0] DIV_FULL_M1 = 10'(`LAIT_DIV_FULL - 1);
    localparam logic [9:0] DIV_HALF_M1 = 10'(`LAIT_DIV_HALF - 1);

    logic rst_s1_r, rst_sync_n_r;
    logic wr_stb;
    logic [7:0] wr_addr, wr_data, rd_addr, rd_data;
    logic [7:0] cmd_r, ctrl_r;
    logic sync_stb, cfg_change, enable, ext_mode, slow_osc, osc_tick;
    lait_res_e res;
    lait_gain_e gain;
    lait_dmode_e dmode;
    logic [9:0] div_cnt_r, div_last;
    logic [15:0] period_m1, tick_cnt_r, data_cnt_r, data_r, timer_r;
    logic active_r, diode_r, result_r, int_done, ext_done, end_int, start_ext;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_r <= 1'b0;
            rst_sync_n_r <= 1'b0;
        end else if (ce) begin
            rst_s1_r <= 1'b1;
            rst_sync_n_r <= rst_s1_r;
        end
    end

    lait_bus_slave u_bus (
        .clk(ref_clk),
        .rst_n(rst_sync_n_r),
        .ce(ce),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .sda_oe(sda_oe),
        .wr_stb(wr_stb),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    assign sda_o = 1'b0;
    assign enable = cmd_r[`LAIT_CMD_ENABLE];
    assign ext_mode = cmd_r[`LAIT_CMD_EXT_TIMING];
    assign res = lait_res_e'(cmd_r[`LAIT_CMD_RES_HI:`LAIT_CMD_RES_LO]);
    assign dmode = lait_dmode_e'(cmd_r[`LAIT_CMD_MODE_HI:`LAIT_CMD_MODE_LO]);
    assign gain = lait_gain_e'(ctrl_r[`LAIT_CTRL_GAIN_HI:`LAIT_CTRL_GAIN_LO]);
    assign sync_stb = wr_stb && wr_addr == `LAIT_ADDR_CMD && wr_data[`LAIT_CMD_SYNC];

    // Sync bit is a trigger and never stored
    always_ff @(posedge ref_clk or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            cmd_r <= `LAIT_CMD_RESET;
            ctrl_r <= `LAIT_CTRL_RESET;
        end else if (ce && wr_stb) begin
            if (wr_addr == `LAIT_ADDR_CMD) begin
                cmd_r <= wr_data;
                cmd_r[`LAIT_CMD_SYNC] <= 1'b0;
            end
            if (wr_addr == `LAIT_ADDR_CTRL) begin
                ctrl_r <= wr_data;
            end
        end
    end

    always_comb begin
        cfg_change = 1'b0;
        if (wr_stb && wr_addr == `LAIT_ADDR_CMD) begin
            if (wr_data[`LAIT_CMD_ENABLE] != cmd_r[`LAIT_CMD_ENABLE] ||
                wr_data[`LAIT_CMD_EXT_TIMING] != cmd_r[`LAIT_CMD_EXT_TIMING] ||
                wr_data[`LAIT_CMD_MODE_HI:`LAIT_CMD_RES_LO] != cmd_r[`LAIT_CMD_MODE_HI:`LAIT_CMD_RES_LO]) begin
                cfg_change = 1'b1;
            end
        end
        if (wr_stb && wr_addr == `LAIT_ADDR_CTRL &&
            wr_data[`LAIT_CTRL_GAIN_HI:`LAIT_CTRL_GAIN_LO] != ctrl_r[`LAIT_CTRL_GAIN_HI:`LAIT_CTRL_GAIN_LO]) begin
            cfg_change = 1'b1;
        end
    end

    assign slow_osc = gain == lowest_gain_setting || gain == second_gain_setting;
    assign div_last = slow_osc ? DIV_HALF_M1 : DIV_FULL_M1;
    assign osc_tick = div_cnt_r == div_last;

    always_ff @(posedge ref_clk or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            div_cnt_r <= 10'h000;
        end else if (ce) begin
            if (cfg_change || osc_tick) begin
                div_cnt_r <= 10'h000;
            end else begin
                div_cnt_r <= div_cnt_r + 10'h001;
            end
        end
    end

    always_comb begin
        case (res)
            lait_res_16: period_m1 = `LAIT_PERIOD_M1_16;
            lait_res_12: period_m1 = `LAIT_PERIOD_M1_12;
            lait_res_8: period_m1 = `LAIT_PERIOD_M1_8;
            lait_res_4: period_m1 = `LAIT_PERIOD_M1_4;
            default: period_m1 = `LAIT_PERIOD_M1_16;
        endcase
    end

    assign int_done = active_r && !ext_mode && osc_tick && tick_cnt_r == period_m1;
    assign ext_done = active_r && ext_mode && sync_stb;
    assign end_int = (int_done || ext_done) && !cfg_change;
    assign start_ext = !active_r && enable && ext_mode && sync_stb && !cfg_change;

    always_ff @(posedge ref_clk or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            active_r <= 1'b0;
        end else if (ce) begin
            if (!enable || cfg_change) begin
                active_r <= 1'b0;
            end else if (!ext_mode || start_ext) begin
                active_r <= 1'b1;
            end
        end
    end

    // counter wraps if host spaces syncs too far
    always_ff @(posedge ref_clk or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            tick_cnt_r <= 16'h0000;
            data_cnt_r <= 16'h0000;
        end else if (ce) begin
            if (cfg_change || !active_r || end_int) begin
                tick_cnt_r <= 16'h0000;
                data_cnt_r <= 16'h0000;
            end else begin
                if (osc_tick) begin
                    tick_cnt_r <= tick_cnt_r + 16'h0001;
                end
                if (adc_pulse && data_cnt_r != 16'hFFFF) begin
                    data_cnt_r <= data_cnt_r + 16'h0001;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            data_r <= 16'h0000;
            timer_r <= 16'h0000;
            result_r <= 1'b0;
        end else if (ce) begin
            result_r <= end_int;
            if (end_int) begin
                data_r <= data_cnt_r;
                if (ext_mode) begin
                    timer_r <= tick_cnt_r;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            diode_r <= 1'b0;
        end else if (ce) begin
            if (dmode != dual_diode_sequence_mode) begin
                diode_r <= dmode == single_diode_mode_b;
            end else if (cfg_change || !active_r) begin
                diode_r <= 1'b0;
            end else if (end_int) begin
                diode_r <= !diode_r;
            end
        end
    end

    assign diode_sel = diode_r;
    assign integrating = active_r;
    assign result_stb = result_r;

    always_comb begin
        case (rd_addr)
            `LAIT_ADDR_CMD: rd_data = cmd_r;
            `LAIT_ADDR_CTRL: rd_data = ctrl_r;
            `LAIT_ADDR_DATA_LO: rd_data = data_r[7:0];
            `LAIT_ADDR_DATA_HI: rd_data = data_r[15:8];
            `LAIT_ADDR_TMR_LO: rd_data = timer_r[7:0];
            `LAIT_ADDR_TMR_HI: rd_data = timer_r[15:8];
            default: rd_data = 8'h00;
        endcase
    end

    // Helper: cycles since last oscillator tick
    logic [9:0] gap_r;
    logic gap_ok_r;
    always_ff @(posedge ref_clk or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            gap_r <= 10'h000;
            gap_ok_r <= 1'b0;
        end else if (ce) begin
            if (cfg_change) begin
                gap_r <= 10'h000;
                gap_ok_r <= 1'b0;
            end else if (osc_tick) begin
                gap_r <= 10'h000;
                gap_ok_r <= 1'b1;
            end else begin
                gap_r <= gap_r + 10'h001;
            end
        end
    end

    default clocking cb @(posedge ref_clk iff ce);
    endclocking
    default disable iff (!rst_sync_n_r);

    sequence s_sync_live;
        ext_mode && sync_stb && !cfg_change && active_r;
    endsequence

    sequence s_sync_first;
        ext_mode && enable && sync_stb && !cfg_change && !active_r;
    endsequence

    a_osc_rate: assert property (osc_tick && gap_ok_r && !cfg_change |->
        gap_r == ((gain == third_gain_setting || gain == highest_gain_setting) ? DIV_FULL_M1 : DIV_HALF_M1))
        else $error("oscillator period wrong for gain");
    a_ext_no_auto: assert property (ext_mode && !sync_stb |-> !end_int)
        else $error("external integration ended without sync");
    a_int_length: assert property (end_int && !ext_mode |-> osc_tick && tick_cnt_r == period_m1)
        else $error("internal integration length wrong");
    a_res_decode: assert property (end_int && !ext_mode |->
        (res != lait_res_4 || tick_cnt_r == 16'h000F) && (res != lait_res_16 || tick_cnt_r == 16'hFFFF))
        else $error("resolution decode wrong");
    a_sync_restart: assert property (s_sync_live |->
        end_int ##1 (active_r && tick_cnt_r == 16'h0000 && result_r))
        else $error("sync did not end and restart");
    a_first_start: assert property (s_sync_first |-> !end_int ##1 (active_r && !result_r))
        else $error("first sync produced a result");
    a_dual_toggle: assert property (end_int && dmode == dual_diode_sequence_mode |=>
        diode_r != $past(diode_r)) else $error("dual mode diode did not alternate");
    a_tick_count: assert property (active_r && osc_tick && !end_int && !cfg_change |=>
        tick_cnt_r == $past(tick_cnt_r) + 16'h0001) else $error("cycle counter missed a tick");
    a_timer_capture: assert property (end_int && ext_mode |=> timer_r == $past(tick_cnt_r))
        else $error("timer bytes not captured");
    a_data_refresh: assert property (end_int |=> data_r == $past(data_cnt_r) && result_r)
        else $error("result bytes not refreshed");
    a_cfg_restart: assert property (cfg_change |=>
        !active_r && tick_cnt_r == 16'h0000 && data_cnt_r == 16'h0000)
        else $error("config change did not restart");

endmodule

`default_nettype wire

// File: tb/lait_host_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "lait_consts.svh"

module lait_host_model (
    input wire logic ref_clk, // Pacing clock
    output logic scl, // Serial clock, idles high
    output logic sda_i, // Resolved data line
    input wire logic sda_oe, // Device pulls data low
    output logic nack_seen // Sticky missing acknowledge
);
    logic drv_low;
    // Pull-up: released line reads high
    assign sda_i = ~(drv_low | sda_oe);
    initial begin
        scl = 1'b1;
        drv_low = 1'b0;
        nack_seen = 1'b0;
    end
    task q(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task frame_start();
        q(4);
        drv_low = 1'b0;
        q(4);
        scl = 1'b1;
        q(8);
        drv_low = 1'b1;
        q(8);
        scl = 1'b0;
    endtask
    task frame_stop();
        q(4);
        drv_low = 1'b1;
        q(4);
        scl = 1'b1;
        q(8);
        drv_low = 1'b0;
        q(8);
    endtask
    // Data only moves while the clock is low
    task bit_io(input logic b, output logic r);
        q(4);
        drv_low = ~b;
        q(4);
        scl = 1'b1;
        q(8);
        r = sda_i;
        scl = 1'b0;
    endtask
    // Ninth bit released: acknowledge on writes, ending refusal on reads
    task xfer(input logic [7:0] d, input logic rd, output logic [7:0] r);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r[i]);
        end
        bit_io(1'b1, a);
        if (!rd && a) begin
            nack_seen = 1'b1;
        end
    endtask
    task write_reg(input logic [7:0] a, input logic [7:0] v);
        logic [7:0] r;
        frame_start();
        xfer({`LAIT_BUS_ADDR, 1'b0}, 1'b0, r);
        xfer(a, 1'b0, r);
        xfer(v, 1'b0, r);
        frame_stop();
    endtask
    task read_reg(input logic [7:0] a, output logic [7:0] v);
        logic [7:0] r;
        frame_start();
        xfer({`LAIT_BUS_ADDR, 1'b0}, 1'b0, r);
        xfer(a, 1'b0, r);
        frame_start();
        xfer({`LAIT_BUS_ADDR, 1'b1}, 1'b0, r);
        xfer(8'hFF, 1'b1, v);
        frame_stop();
    endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "lait_consts.svh"

module tb;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic adc_pulse = 1'b0;
    logic scl, sda_i, sda_o, sda_oe, diode_sel, integrating, result_stb, nack_seen, integ_q;
    int errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    int stb_count = 0;
    int last_stb = 0;
    int prev_stb = 0;
    int drops = 0;
    logic [7:0] lo, hi;

    always #2 ref_clk = ~ref_clk;
    // One modulator count in four cycles
    always @(negedge ref_clk) begin
        adc_pulse <= (cyc % 4 == 0);
        cyc <= cyc + 1;
        integ_q <= integrating;
        if (integ_q === 1'b1 && integrating === 1'b0) begin
            drops <= drops + 1;
        end
        if (result_stb === 1'b1) begin
            stb_count <= stb_count + 1;
            prev_stb <= last_stb;
            last_stb <= cyc;
        end
    end

    lait_top u_dut (.ref_clk, .rst_n, .ce, .scl_i(scl), .sda_i, .sda_o, .sda_oe, .adc_pulse, .diode_sel,
        .integrating, .result_stb);
    lait_host_model u_host (.ref_clk, .scl, .sda_i, .sda_oe, .nack_seen);

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task wait_stb(input int target);
        for (int k = 0; k < 40000 && stb_count < target; k++) begin
            @(negedge ref_clk);
        end
    endtask
    task t_reset();
        chk({sda_o, sda_oe, diode_sel, integrating, result_stb}, 5'h00);
        u_host.read_reg(8'h00, lo);
        chk(lo, 8'h00);
        u_host.read_reg(8'h01, lo);
        chk(lo, 8'h00);
        u_host.read_reg(8'h1F, lo);
        chk(lo, 8'h00);
        u_host.write_reg(8'h04, 8'h5A);
        u_host.read_reg(8'h04, lo);
        chk(lo, 8'h00);
    endtask
    task t_internal(input logic [1:0] gain, input int div, input logic [1:0] mode);
        int t, p;
        u_host.write_reg(8'h01, {4'h0, gain, 2'b00});
        u_host.write_reg(8'h00, {4'h8, mode, 2'b11});
        t = stb_count + 2;
        wait_stb(t);
        chk(stb_count, t);
        p = 16 * div;
        chk(last_stb - prev_stb, p);
        u_host.read_reg(8'h04, lo);
        u_host.read_reg(8'h05, hi);
        chk(({hi, lo} >= p / 4 - 2) && ({hi, lo} <= p / 4 + 2), 1'b1);
        chk(integrating, 1'b1);
        chk(diode_sel, mode == 2'b01);
    endtask
    task t_external();
        int t, el;
        u_host.write_reg(8'h01, 8'h0C);
        u_host.write_reg(8'h00, 8'hAC);
        t = stb_count;
        u_host.write_reg(8'h00, 8'hEC);
        repeat (4000) @(negedge ref_clk);
        chk(stb_count, t);
        chk({integrating, diode_sel}, 2'b10);
        for (int i = 1; i <= 2; i++) begin
            // spacing far below the counter range
            u_host.write_reg(8'h00, 8'hEC);
            wait_stb(t + i);
            chk(stb_count, t + i);
            chk(diode_sel, i % 2);
            repeat (4000) @(negedge ref_clk);
        end
        el = (last_stb - prev_stb) / `LAIT_DIV_FULL;
        u_host.read_reg(8'h06, lo);
        u_host.read_reg(8'h07, hi);
        chk(({hi, lo} + 1 >= el) && ({hi, lo} <= el + 1), 1'b1);
    endtask
    task final_report();
        if (errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        int d;
        repeat (3) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        t_reset();
        t_internal(2'b11, `LAIT_DIV_FULL, 2'b00);
        d = drops;
        t_internal(2'b00, `LAIT_DIV_HALF, 2'b01);
        chk(drops > d, 1'b1);
        t_external();
        chk(nack_seen, 1'b0);
        final_report();
    end
    // Run needs about 240 us
    initial begin
        #360000;
        errors++;
        final_report();
    end
endmodule
`default_nettype wire
